// >>> rtl/sct_timers.sv
// card protocol timers: waiting, answer duration, first char, reset release.
// assumes etu_tick_i is a one-cycle strobe on clock_i; card pins are async.
// Contract
// - one 16-bit limit serves as character or initial waiting time.
// - waiting timer counts etus between consecutive received start-bit edges.
// - in block protocol it is character wait, during answer initial wait.
// - waiting interval exceeded raises an interrupt to firmware.
// - 16-bit answer limit bounds first-to-last char time; excess is timeout.
// - answer timer enabled by receive bit, starts at first edge, stops on clear.
// - with detection on, 8-bit first-char timer runs from card reset release.
// - first char missing within its limit reports answer timeout, mute card; code sets the separate mute status bit, not answer timeout.
// - 8-bit reset delay in etus, reset value 0x70.
// - delay zero and hold clear releases reset once supply ok.
// - setting hold bit drives card reset pin low.
// - clearing hold bit releases reset after programmed delay.
// - hold set before power keeps reset until delay after clearing.
// - reset control acts only on the selected card interface.
//
// Our own choice: the strobed register port.
module sct_timers (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire sct_pkg::sct_bus_req_t bus_i,
   input wire logic etu_tick_i,
   input wire logic card_io_i,
   input wire logic card_supply_ok_i,
   output logic [7:0] rdata_o,
   output logic irq_o,
   output logic [sct_pkg::N_IF-1:0] card_rst_n_o
);
   sct_pkg::sct_state_t state_reg;
   sct_pkg::sct_state_t state_next;

   logic io_agree;
   logic vok_agree;
   logic start_edge;
   logic supply_ok;
   logic hold;
   logic sel;
   logic released;
   logic [2:0] events;

   // a pin change counts once the second and third stages agree;
   // costs a cycle, but a one-cycle glitch never reaches the timers
   assign io_agree = state_reg.io_sync[1] == state_reg.io_sync[2];
   assign vok_agree = state_reg.vok_sync[1] == state_reg.vok_sync[2];
   assign start_edge =
      io_agree && !state_reg.io_sync[2] && state_reg.io_level;
   assign supply_ok = state_reg.supply_level;
   assign hold = state_reg.control[sct_pkg::CTL_RESET_HOLD];
   assign sel = state_reg.control[sct_pkg::CTL_SELECT];

   always_comb begin
      state_next = state_reg;
      released = 1'b0;
      events = 3'h0;

      state_next.io_sync = {state_reg.io_sync[1:0], card_io_i};
      state_next.vok_sync = {state_reg.vok_sync[1:0], card_supply_ok_i};
      if (io_agree) begin
         state_next.io_level = state_reg.io_sync[2];
      end
      if (vok_agree) begin
         state_next.supply_level = state_reg.vok_sync[2];
      end

      // waiting timer, one limit for both waits
      if (start_edge) begin
         state_next.wt_run = 1'b1;
         state_next.wt_cnt = 16'h0000;
      end else if (etu_tick_i && state_reg.wt_run) begin
         // limit of zero would fire on the first tick; firmware avoids it
         if (state_reg.wt_cnt == state_reg.char_wait_limit) begin
            events[sct_pkg::EVT_WAIT] = 1'b1;
            state_next.wt_run = 1'b0;
         end else begin
            state_next.wt_cnt = state_reg.wt_cnt + 16'h0001;
         end
      end

      // answer duration timer
      if (!state_reg.control[sct_pkg::CTL_RECEIVE_ANSWER]) begin
         state_next.at_armed = 1'b0;
         state_next.at_run = 1'b0;
         state_next.at_cnt = 16'h0000;
      end else if (!state_reg.at_armed) begin
         if (start_edge) begin
            state_next.at_armed = 1'b1;
            state_next.at_run = 1'b1;
            state_next.at_cnt = 16'h0000;
         end
      end else if (etu_tick_i && state_reg.at_run) begin
         if (state_reg.at_cnt == state_reg.answer_duration_limit) begin
            events[sct_pkg::EVT_ANSWER] = 1'b1;
            state_next.at_run = 1'b0;
         end else begin
            state_next.at_cnt = state_reg.at_cnt + 16'h0001;
         end
      end

      // reset release sequencing
      case (state_reg.rst_state)
         sct_pkg::SCT_HOLD: begin
            state_next.rd_cnt = 8'h00;
            if (supply_ok && !hold) begin
               if (state_reg.reset_delay == 8'h00) begin
                  state_next.rst_state = sct_pkg::SCT_RELEASED;
                  released = 1'b1;
               end else begin
                  state_next.rst_state = sct_pkg::SCT_DELAY;
               end
            end
         end
         sct_pkg::SCT_DELAY: begin
            if (!supply_ok || hold) begin
               state_next.rst_state = sct_pkg::SCT_HOLD;
            end else if (etu_tick_i) begin
               if (state_reg.rd_cnt + 8'h01 >= state_reg.reset_delay) begin
                  state_next.rst_state = sct_pkg::SCT_RELEASED;
                  released = 1'b1;
               end else begin
                  state_next.rd_cnt = state_reg.rd_cnt + 8'h01;
               end
            end
         end
         sct_pkg::SCT_RELEASED: begin
            if (!supply_ok || hold) begin
               state_next.rst_state = sct_pkg::SCT_HOLD;
            end
         end
         default: begin
            state_next.rst_state = sct_pkg::SCT_HOLD;
         end
      endcase

      // unselected interfaces stay in reset
      state_next.card_rst_n = '0;
      state_next.card_rst_n[sel] =
         (state_next.rst_state == sct_pkg::SCT_RELEASED);

      // first char timer
      if (released && state_reg.control[sct_pkg::CTL_DETECT_FIRST]) begin
         state_next.ts_run = 1'b1;
         state_next.ts_cnt = 8'h00;
      end else if (start_edge || state_next.rst_state != sct_pkg::SCT_RELEASED)
      begin
         state_next.ts_run = 1'b0;
      end else if (etu_tick_i && state_reg.ts_run) begin
         if (state_reg.ts_cnt == state_reg.first_char_limit) begin
            events[sct_pkg::EVT_MUTE] = 1'b1;
            state_next.ts_run = 1'b0;
         end else begin
            state_next.ts_cnt = state_reg.ts_cnt + 8'h01;
         end
      end

      // register writes; limits loaded ahead of traffic
      if (bus_i.wr) begin
         case (bus_i.addr)
            sct_pkg::ADDR_CHAR_WAIT_HIGH:
               state_next.char_wait_limit[15:8] = bus_i.wdata;
            sct_pkg::ADDR_CHAR_WAIT_LOW:
               state_next.char_wait_limit[7:0] = bus_i.wdata;
            sct_pkg::ADDR_ANSWER_TO_HIGH:
               state_next.answer_duration_limit[15:8] = bus_i.wdata;
            sct_pkg::ADDR_ANSWER_TO_LOW:
               state_next.answer_duration_limit[7:0] = bus_i.wdata;
            sct_pkg::ADDR_FIRST_CHAR_TO:
               state_next.first_char_limit = bus_i.wdata;
            sct_pkg::ADDR_RESET_DELAY:
               state_next.reset_delay = bus_i.wdata;
            sct_pkg::ADDR_CONTROL:
               state_next.control = bus_i.wdata;
            sct_pkg::ADDR_STATUS:
               state_next.status = state_reg.status & ~bus_i.wdata[2:0];
            sct_pkg::ADDR_MASK:
               state_next.mask = bus_i.wdata[2:0];
            default: begin
            end
         endcase
      end
      // a new event beats a clear in the same cycle
      state_next.status = state_next.status | events;
      state_next.irq = |(state_next.status & state_next.mask);

      // read data valid in the cycle after the strobe, zero otherwise
      state_next.rdata = 8'h00;
      if (bus_i.rd) begin
         case (bus_i.addr)
            sct_pkg::ADDR_CHAR_WAIT_HIGH:
               state_next.rdata = state_reg.char_wait_limit[15:8];
            sct_pkg::ADDR_CHAR_WAIT_LOW:
               state_next.rdata = state_reg.char_wait_limit[7:0];
            sct_pkg::ADDR_ANSWER_TO_HIGH:
               state_next.rdata = state_reg.answer_duration_limit[15:8];
            sct_pkg::ADDR_ANSWER_TO_LOW:
               state_next.rdata = state_reg.answer_duration_limit[7:0];
            sct_pkg::ADDR_FIRST_CHAR_TO:
               state_next.rdata = state_reg.first_char_limit;
            sct_pkg::ADDR_RESET_DELAY:
               state_next.rdata = state_reg.reset_delay;
            sct_pkg::ADDR_CONTROL:
               state_next.rdata = state_reg.control;
            sct_pkg::ADDR_STATUS:
               state_next.rdata = {5'h00, state_reg.status};
            sct_pkg::ADDR_MASK:
               state_next.rdata = {5'h00, state_reg.mask};
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         // idle card line is high; avoid a false start edge after reset
         state_reg.io_sync <= sct_pkg::RST_IO_SYNC;
         state_reg.io_level <= sct_pkg::RST_IO_LEVEL;
         state_reg.vok_sync <= sct_pkg::RST_VOK_SYNC;
         state_reg.supply_level <= sct_pkg::RST_SUPPLY_LEVEL;
         state_reg.rdata <= 8'h00;
         state_reg.irq <= 1'h0;
         state_reg.wt_run <= 1'h0;
         state_reg.wt_cnt <= 16'h0000;
         state_reg.at_armed <= 1'h0;
         state_reg.at_run <= 1'h0;
         state_reg.at_cnt <= 16'h0000;
         state_reg.ts_run <= 1'h0;
         state_reg.ts_cnt <= 8'h00;
         state_reg.rd_cnt <= 8'h00;
         state_reg.card_rst_n <= '0;
         state_reg.char_wait_limit <= {sct_pkg::RST_LIMIT, sct_pkg::RST_LIMIT};
         state_reg.answer_duration_limit <=
            {sct_pkg::RST_LIMIT, sct_pkg::RST_LIMIT};
         state_reg.first_char_limit <= sct_pkg::RST_LIMIT;
         state_reg.reset_delay <= sct_pkg::RST_RESET_DELAY;
         state_reg.control <= sct_pkg::RST_CONTROL;
         state_reg.status <= sct_pkg::RST_EVENTS;
         state_reg.mask <= sct_pkg::RST_EVENTS;
         state_reg.rst_state <= sct_pkg::SCT_HOLD;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rdata_o = state_reg.rdata;
   assign irq_o = state_reg.irq;
   assign card_rst_n_o = state_reg.card_rst_n;
endmodule // sct_timers

// >>> rtl/sct_pkg.sv
// constants, register map and state types of the card protocol timers.
// assumes one 10 MHz clock and an etu tick strobe on that clock.
package sct_pkg;
   // register byte addresses
   localparam logic [15:0] ADDR_CHAR_WAIT_HIGH = 16'hFE1C;
   localparam logic [15:0] ADDR_CHAR_WAIT_LOW = 16'hFE1D;
   localparam logic [15:0] ADDR_ANSWER_TO_HIGH = 16'hFE1F;
   localparam logic [15:0] ADDR_ANSWER_TO_LOW = 16'hFE20;
   localparam logic [15:0] ADDR_FIRST_CHAR_TO = 16'hFE21;
   localparam logic [15:0] ADDR_RESET_DELAY = 16'hFE22;
   localparam logic [15:0] ADDR_CONTROL = 16'hFE24;
   localparam logic [15:0] ADDR_STATUS = 16'hFE25;
   localparam logic [15:0] ADDR_MASK = 16'hFE26;
   // reset values
   localparam logic [7:0] RST_LIMIT = 8'h00;
   localparam logic [7:0] RST_RESET_DELAY = 8'h70;
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [2:0] RST_EVENTS = 3'h0;
   // card line idles high, card supply starts absent
   localparam logic [2:0] RST_IO_SYNC = 3'h7;
   localparam logic RST_IO_LEVEL = 1'h1;
   localparam logic [2:0] RST_VOK_SYNC = 3'h0;
   localparam logic RST_SUPPLY_LEVEL = 1'h0;
   // control register fields
   localparam int CTL_RECEIVE_ANSWER = 0;
   localparam int CTL_DETECT_FIRST = 1;
   localparam int CTL_RESET_HOLD = 7;
   localparam int CTL_SELECT = 4;
   // status and mask fields
   localparam int EVT_WAIT = 0;
   localparam int EVT_ANSWER = 1;
   localparam int EVT_MUTE = 2;
   localparam int N_IF = 2;

   typedef enum logic [1:0] {
      SCT_HOLD = 2'h0,
      SCT_DELAY = 2'h1,
      SCT_RELEASED = 2'h2
   } sct_rst_state_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } sct_bus_req_t;

   typedef struct packed {
      logic [2:0] io_sync;
      logic [2:0] vok_sync;
      logic io_level;
      logic supply_level;
      logic [15:0] char_wait_limit;
      logic [15:0] answer_duration_limit;
      logic [7:0] first_char_limit;
      logic [7:0] reset_delay;
      logic [7:0] control;
      logic [2:0] status;
      logic [2:0] mask;
      logic [7:0] rdata;
      logic irq;
      logic wt_run;
      logic [15:0] wt_cnt;
      logic at_armed;
      logic at_run;
      logic [15:0] at_cnt;
      logic ts_run;
      logic [7:0] ts_cnt;
      sct_rst_state_t rst_state;
      logic [7:0] rd_cnt;
      logic [N_IF-1:0] card_rst_n;
   } sct_state_t;
endpackage

// >>> bench/sct_timers_asserts.sv
// checker for the card protocol timers, on top-level ports only.
// assumes one clock domain and the register map of sct_pkg.
module sct_timers_asserts (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire sct_pkg::sct_bus_req_t bus_i,
   input wire logic etu_tick_i,
   input wire logic card_io_i,
   input wire logic card_supply_ok_i,
   input wire logic [7:0] rdata_o,
   input wire logic irq_o,
   input wire logic [sct_pkg::N_IF-1:0] card_rst_n_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   property p_rd_idle; !$past(bus_i.rd) |-> rdata_o == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside read slot");
   property p_unmap; bus_i.rd && bus_i.addr == 16'hFE1E |=> !rdata_o;
   endproperty
   a_unmap: assert property (p_unmap)
      else $error("unmapped read not zero");
   property p_stat; bus_i.rd && bus_i.addr == sct_pkg::ADDR_STATUS
      |=> rdata_o[7:3] == 5'h00; endproperty
   a_stat: assert property (p_stat)
      else $error("status upper bits set");
   property p_one_if; $onehot0(card_rst_n_o); endproperty
   a_one_if: assert property (p_one_if)
      else $error("unselected card released");
   property p_hold; bus_i.wr && bus_i.addr == sct_pkg::ADDR_CONTROL &&
      bus_i.wdata[7] |-> ##[1:2] card_rst_n_o == 2'h0; endproperty
   a_hold: assert property (p_hold)
      else $error("hold bit did not assert card reset");
   property p_supply; !card_supply_ok_i [*6] |=> !card_rst_n_o; endproperty
   a_supply: assert property (p_supply)
      else $error("card released without supply");
   property p_rel; $rose(|card_rst_n_o) |-> $past(card_supply_ok_i, 4);
   endproperty
   a_rel: assert property (p_rel)
      else $error("release too soon after supply");
   // irq is registered, so its cause lies one edge back; the check also accepts two
   property p_irq; $rose(irq_o) |-> $past(etu_tick_i) ||
      $past(etu_tick_i, 2) || $past(bus_i.wr) || $past(bus_i.wr, 2);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt without tick or write");
   c_irq: cover property ($rose(irq_o));
   c_rel: cover property ($rose(card_rst_n_o[1]));
   c_rd: cover property (bus_i.rd ##1 rdata_o != 8'h00);
endmodule // sct_timers_asserts

bind sct_timers sct_timers_asserts u_chk (.clock_i(clock_i),
   .rst_n_i(rst_n_i), .bus_i(bus_i), .etu_tick_i(etu_tick_i),
   .card_io_i(card_io_i), .card_supply_ok_i(card_supply_ok_i),
   .rdata_o(rdata_o), .irq_o(irq_o), .card_rst_n_o(card_rst_n_o));

// >>> bench/sct_card_model.sv
// card model: sends a start bit on the io line when asked.
// assumes a pulled-up line; a card in reset stays silent.
module sct_card_model (
   input wire logic clock_i,
   input wire logic card_rst_n_i,
   input wire logic send_i,
   output logic io_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int low_cnt = 0;
   always @(posedge clock_i) begin
      if (send_i && card_rst_n_i)
         low_cnt <= 4;
      else if (low_cnt > 0)
         low_cnt <= low_cnt - 1;
   end
   // released line returns to the pull-up level
   assign io_o = (low_cnt > 0) ? 1'b0 : 1'b1;
endmodule // sct_card_model

// >>> bench/tb.sv
// self-checking bench for the card protocol timers.
// assumes a 10 MHz clock; etu tick every fourth clock keeps runs short.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock_i = 0, rst_n_i = 0, tick = 0, supply = 0, send = 0;
   sct_pkg::sct_bus_req_t bus = '0;
   logic [7:0] rdata;
   logic irq, io;
   logic [sct_pkg::N_IF-1:0] crst;
   logic [1:0] tdiv = 0;
   int failures = 0, checks_done = 0;
   sct_timers dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus_i(bus),
      .etu_tick_i(tick), .card_io_i(io), .card_supply_ok_i(supply),
      .rdata_o(rdata), .irq_o(irq), .card_rst_n_o(crst));
   sct_card_model card (.clock_i(clock_i), .card_rst_n_i(|crst),
      .send_i(send), .io_o(io));
   initial forever #50 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      tdiv <= tdiv + 2'h1;
      tick <= (tdiv == 2'h3);
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock_i);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock_i);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clock_i);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clock_i);
      bus.rd <= 1'b0;
      @(negedge clock_i);
      chk(rdata, e);
   endtask
   // waits bounded for {irq, card resets}, then compares
   task automatic pins(input logic [2:0] e);
      int n;
      n = 0;
      @(negedge clock_i);
      while ({irq, crst} !== e && n < 300) begin
         @(negedge clock_i);
         n++;
      end
      chk({5'h00, irq, crst}, {5'h00, e});
   endtask
   task automatic t_regs();
      rd(sct_pkg::ADDR_RESET_DELAY, 8'h70);
      rd(sct_pkg::ADDR_ANSWER_TO_HIGH, 8'h00);
      rd(sct_pkg::ADDR_FIRST_CHAR_TO, 8'h00);
      wr(sct_pkg::ADDR_CHAR_WAIT_HIGH, 8'hA5);
      rd(sct_pkg::ADDR_CHAR_WAIT_HIGH, 8'hA5);
      rd(16'hFE1E, 8'h00);
      $display("regs done");
   endtask
   task automatic t_reset();
      wr(sct_pkg::ADDR_CONTROL, 8'h80);
      supply <= 1'b1;
      repeat (20) @(posedge clock_i);
      pins(3'h0);
      wr(sct_pkg::ADDR_RESET_DELAY, 8'h02);
      wr(sct_pkg::ADDR_CONTROL, 8'h00);
      // at most one tick can pass in these cycles, delay is two
      repeat (3) @(negedge clock_i);
      chk({6'h00, crst}, 8'h00);
      pins(3'h1);
      wr(sct_pkg::ADDR_CONTROL, 8'h90);
      pins(3'h0);
      wr(sct_pkg::ADDR_RESET_DELAY, 8'h00);
      wr(sct_pkg::ADDR_CONTROL, 8'h10);
      pins(3'h2);
      $display("reset done");
   endtask
   task automatic t_wait();
      wr(sct_pkg::ADDR_CHAR_WAIT_HIGH, 8'h00);
      wr(sct_pkg::ADDR_CHAR_WAIT_LOW, 8'h03);
      wr(sct_pkg::ADDR_MASK, 8'h01);
      repeat (4) begin
         @(posedge clock_i) send <= 1'b1;
         @(posedge clock_i) send <= 1'b0;
         repeat (8) @(posedge clock_i);
      end
      @(negedge clock_i);
      chk({7'h00, irq}, 8'h00);
      pins(3'h6);
      rd(sct_pkg::ADDR_STATUS, 8'h01);
      wr(sct_pkg::ADDR_STATUS, 8'h01);
      pins(3'h2);
      $display("wait done");
   endtask
   task automatic t_mute();
      wr(sct_pkg::ADDR_CHAR_WAIT_LOW, 8'hFF);
      wr(sct_pkg::ADDR_ANSWER_TO_LOW, 8'h02);
      wr(sct_pkg::ADDR_FIRST_CHAR_TO, 8'h05);
      wr(sct_pkg::ADDR_MASK, 8'h06);
      wr(sct_pkg::ADDR_CONTROL, 8'h01);
      @(posedge clock_i) send <= 1'b1;
      @(posedge clock_i) send <= 1'b0;
      pins(3'h5);
      rd(sct_pkg::ADDR_STATUS, 8'h02);
      wr(sct_pkg::ADDR_STATUS, 8'h02);
      wr(sct_pkg::ADDR_CONTROL, 8'h82);
      pins(3'h0);
      wr(sct_pkg::ADDR_CONTROL, 8'h02);
      pins(3'h5);
      rd(sct_pkg::ADDR_STATUS, 8'h04);
      // first char arriving in time stops the mute timer
      wr(sct_pkg::ADDR_STATUS, 8'h04);
      wr(sct_pkg::ADDR_CONTROL, 8'h82);
      pins(3'h0);
      wr(sct_pkg::ADDR_CONTROL, 8'h02);
      @(posedge clock_i) send <= 1'b1;
      @(posedge clock_i) send <= 1'b0;
      repeat (40) @(posedge clock_i);
      rd(sct_pkg::ADDR_STATUS, 8'h00);
      $display("mute done");
   endtask
   task automatic test_done();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #2000000;
      failures++;
      test_done();
   end
   initial begin
      repeat (6) @(posedge clock_i);
      rst_n_i <= 1'b1;
      t_regs();
      t_reset();
      t_wait();
      t_mute();
      test_done();
   end
endmodule // tb
